// ==== ovr_map.svh ====
// Purpose: constants for the output overvoltage fault response block
// Assumes: 100 MHz clock
// Notes:   offsets are byte command codes of the management port
`ifndef OVR_MAP_SVH
`define OVR_MAP_SVH
`define OVR_CFG_CMD       8'h41
`define OVR_CFG_RESET     8'hb8
`define OVR_CODE_PULLDOWN 8'h00
`define OVR_CODE_OFF      8'h80
`define OVR_CODE_RETRY    8'hb8
`define OVR_RESP_MSB      7
`define OVR_RESP_LSB      6
`define OVR_RETRY_MSB     5
`define OVR_RETRY_LSB     3
`define OVR_DLY_MSB       2
`define OVR_DLY_LSB       0
`define OVR_STEP_NS       10000
`define OVR_CLK_NS        10
`define OVR_STEP_CYC      (`OVR_STEP_NS / `OVR_CLK_NS)
`define OVR_RETRY_MS      350
`define OVR_RETRY_CYC     (`OVR_RETRY_MS * 100000)
`endif

// ==== ovr_pkg.sv ====
// Purpose: types for the output overvoltage fault response block
// Assumes: nothing
// Notes:   state codes are one-hot
package ovr_pkg;
   typedef enum logic [3:0] {
      OVR_RUN   = 4'h1,
      OVR_DEGL  = 4'h2,
      OVR_OFF   = 4'h4,
      OVR_WAIT  = 4'h8
   } ovr_state_t;
   typedef struct packed {
      logic status_byte_ov;
      logic status_word_vout;
      logic status_vout_ov;
   } ovr_flags_t;
endpackage

// ==== ovr_timer.sv ====
// Purpose: loadable down counter with done flag
// Assumes: single clock
// Notes:   done is high while the count is zero and not loading
`timescale 1ns/10ps
module ovr_timer import ovr_pkg::*; #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   input  wire logic         run,
   // status
   output logic              done
);
   logic [W-1:0] cnt_q;   // remaining cycles

   // count down while running, hold at zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= value;
      end else if (run && cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end
   assign done = (cnt_q == '0) && !load;
endmodule

// ==== ovr_resp.sv ====
// Purpose: output overvoltage fault response for one channel
// Assumes: management port writes are one-cycle strobes on clk
// Notes:   comparator and run inputs come from pins, synchronised; op_on is used as is
//
// Functional notes
// - fault sets summary, word and vout flags
// - alert asserted on fault unless masked
// - code 00 pulls output down only
// - code 80 disables output, restarts only on off-on or reset command
// - code b8 disables and retries without limit
// - code 4n deglitched shutdown, no retry
// - code 78+n deglitched shutdown, then retries
// - other codes ignored, raise comm fault
// - byte: response, retry, delay fields
// - response 01 runs for delay first
// - response 10 disables output immediately
// - response 11 unsupported, comm fault
// - flag sticky until clear, off-on, power
// - delay counts ten microsecond steps
// - retry field: never or unlimited
// - retry 000 means no restart
// - retry timer starts at fault detection
`timescale 1ns/10ps
`include "ovr_map.svh"
module ovr_resp import ovr_pkg::*; #(
   parameter int RETRY_CYC = `OVR_RETRY_CYC,   // retry interval
   parameter int STEP_CYC  = `OVR_STEP_CYC     // one delay step
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // management port
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_cmd,
   input  wire logic [7:0] wr_data,
   input  wire logic       clear_faults,
   input  wire logic       reset_cmd,
   output logic [7:0]      cfg_rd,
   output logic            cml_fault,
   // channel control
   input  wire logic       ov_pin,
   input  wire logic       run_pin,
   input  wire logic       op_on,
   input  wire logic       other_fault_off,
   input  wire logic       alert_mask,
   // outputs
   output ovr_flags_t      flags,
   output logic            alert_n,
   output logic            out_enable,
   output logic            top_off,
   output logic            bot_on
);
   // ==========================================================
   // input synchronisers
   logic [1:0] ov_s_q, run_s_q;   // two-stage sync chains
   logic       ov, run_on, on_q, on_cmd, on_fall;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ov_s_q  <= 2'h0;
         run_s_q <= 2'h0;
      end else begin
         ov_s_q  <= {ov_s_q[0], ov_pin};
         run_s_q <= {run_s_q[0], run_pin};
      end
   end
   assign ov     = ov_s_q[1];
   assign run_on = run_s_q[1];
   assign on_cmd = run_on && op_on;   // combined on request
   // remember on request to spot on-then-off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) on_q <= 1'b0;
      else       on_q <= on_cmd;
   end
   assign on_fall = on_q && !on_cmd;

   // ==========================================================
   // configuration byte
   logic [7:0] cfg_q;      // stored response
   logic       legal;      // written value is a listed code
   logic [1:0] resp;
   logic [2:0] retry, dly;
   always_comb begin
      legal = (wr_data == `OVR_CODE_PULLDOWN) ||
              (wr_data == `OVR_CODE_OFF) ||
              (wr_data == `OVR_CODE_RETRY) ||
              (wr_data[7:3] == 5'h08) ||    // 0x40..0x47
              (wr_data[7:3] == 5'h0f);      // 0x78..0x7f
   end
   // illegal values are dropped, the stored byte stays
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_q <= `OVR_CFG_RESET;
      end else if (wr_en && wr_cmd == `OVR_CFG_CMD && legal) begin
         cfg_q <= wr_data;
      end
   end
   // response 11 is never legal, so it faults too
   always_ff @(posedge clk or posedge reset) begin
      if (reset) cml_fault <= 1'b0;
      else       cml_fault <= wr_en && wr_cmd == `OVR_CFG_CMD
                              && !legal;
   end
   assign cfg_rd = cfg_q;
   assign resp   = cfg_q[`OVR_RESP_MSB:`OVR_RESP_LSB];
   assign retry  = cfg_q[`OVR_RETRY_MSB:`OVR_RETRY_LSB];
   assign dly    = cfg_q[`OVR_DLY_MSB:`OVR_DLY_LSB];

   // ==========================================================
   // state machine
   ovr_state_t st_q;
   logic       degl_done, rt_load, rt_done, step_q_done;
   logic [31:0] step_cnt_q;   // cycles inside one 10 us step
   logic [2:0]  steps_q;      // whole steps seen so far
   logic        degl_hit;     // persistence reached
   logic        restart;      // leave off by command or reset
   assign restart  = on_fall || reset_cmd;
   assign degl_hit = (steps_q == dly);   // n steps elapsed
   assign step_q_done = (step_cnt_q == 32'(STEP_CYC - 1));

   // 10 us step counter, restarts when ov goes away
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         step_cnt_q <= 32'h0;
         steps_q    <= 3'h0;
      end else if (st_q != OVR_DEGL || !ov) begin
         step_cnt_q <= 32'h0;
         steps_q    <= 3'h0;
      end else if (step_q_done) begin
         step_cnt_q <= 32'h0;
         if (!degl_hit) steps_q <= steps_q + 3'h1;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h1;
      end
   end
   assign degl_done = degl_hit;
   // retry timer loads at fault detection
   assign rt_load = (st_q == OVR_RUN) && ov && resp != 2'h0;
   ovr_timer #(.W(32)) u_retry (
      .clk   (clk),
      .reset (reset),
      .load  (rt_load),
      .value (32'(RETRY_CYC)),
      .run   (1'b1),
      .done  (rt_done)
   );

   // fault response sequencing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= OVR_RUN;
      end else begin
         unique case (st_q)
            OVR_RUN: begin
               if (ov && resp == 2'h1) st_q <= OVR_DEGL;
               else if (ov && resp == 2'h2) st_q <= OVR_OFF;
            end
            OVR_DEGL: begin
               if (!ov) st_q <= OVR_RUN;
               else if (degl_done) st_q <= OVR_OFF;
            end
            OVR_OFF: begin
               if (restart) st_q <= OVR_RUN;
               else if (other_fault_off) st_q <= OVR_OFF;
               else if (retry != 3'h0) st_q <= OVR_WAIT;
               // retry 000 stays off
            end
            OVR_WAIT: begin
               if (restart || !on_cmd) st_q <= OVR_RUN;
               else if (other_fault_off) st_q <= OVR_OFF;
               else if (rt_done && !ov) st_q <= OVR_RUN;
            end
            default: st_q <= OVR_RUN;
         endcase
      end
   end
   // output off while shut down, pulldown while above limit and not shut down
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_enable <= 1'b1;
         top_off    <= 1'b0;
         bot_on     <= 1'b0;
      end else begin
         out_enable <= (st_q == OVR_RUN) || (st_q == OVR_DEGL);
         top_off    <= ov;
         bot_on     <= ov && st_q != OVR_OFF && st_q != OVR_WAIT;
      end
   end

   // ==========================================================
   // sticky status flags; set wins over clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags <= '0;
      end else if (ov) begin
         flags <= '1;
      end else if (clear_faults || on_fall) begin
         flags <= '0;
      end
   end
   // alert follows the sticky flag unless masked
   always_ff @(posedge clk or posedge reset) begin
      if (reset) alert_n <= 1'b1;
      else       alert_n <= !((flags.status_vout_ov || ov) && !alert_mask);
   end

   // ==========================================================
   a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
      $rose(ov) |=> flags.status_vout_ov)
      else $error("ov flag not set");
   a_alert_rise: assert property (@(posedge clk) disable iff (reset)
      (ov && !alert_mask) |=> !alert_n)
      else $error("alert missing");
   a_bad_write: assert property (@(posedge clk) disable iff (reset)
      (wr_en && wr_cmd == `OVR_CFG_CMD && wr_data[7:6] == 2'h3)
      |=> cml_fault && $stable(cfg_q))
      else $error("bad code accepted");
   a_cfg_keep: assert property (@(posedge clk) disable iff (reset)
      (wr_en && !legal) |=> cfg_q == $past(cfg_q))
      else $error("cfg changed on illegal write");
   a_immed_off: assert property (@(posedge clk) disable iff (reset)
      (st_q == OVR_RUN && ov && resp == 2'h2) |=> ##1 !out_enable)
      else $error("no immediate shutdown");
   a_no_retry: assert property (@(posedge clk) disable iff (reset)
      (st_q == OVR_OFF && retry == 3'h0 && !restart)
      |=> st_q == OVR_OFF)
      else $error("restart with retry 000");
   a_pulldown: assert property (@(posedge clk) disable iff (reset)
      (resp == 2'h0 && ov) |=> top_off && out_enable)
      else $error("pulldown mode shut down");
   a_degl_reset: assert property (@(posedge clk) disable iff (reset)
      (st_q == OVR_DEGL && !ov) |=> steps_q == 3'h0)
      else $error("deglitch count kept");
endmodule

// ==== ovr_host.sv ====
// Purpose: host model that services alerts
// Assumes: shares the block clock
// Notes:   clears faults only while asked to
`timescale 1ns/10ps
module ovr_host import ovr_pkg::*; (
   // clock
   input  wire logic       clk,
   // block side
   input  wire logic       alert_n,
   input  wire ovr_flags_t flags,
   // bench control
   input  wire logic       ack_req,
   output ovr_flags_t      seen,
   output logic            clear_faults
);
   // ==================================
   // alert service
   logic pend_q;   // cleared once, waiting for alert to lift
   logic take;     // alert seen and not yet serviced
   initial clear_faults = 1'b0;
   initial seen = '0;
   initial pend_q = 1'b0;
   assign take = ack_req && alert_n === 1'b0 && !pend_q;
   // read status on alert, clear once, then wait for alert to lift;
   // alert lags the flag clear, so a second read would see empty
   // flags and hide what was reported
   always @(posedge clk) begin
      clear_faults <= take;
      if (alert_n === 1'b1) begin
         pend_q <= 1'b0;
      end else if (take) begin
         seen   <= flags;
         pend_q <= 1'b1;
      end
   end
endmodule

// ==== output_overvoltage_fault_response_tb_top.sv ====
// Purpose: self-checking bench for the overvoltage response
// Assumes: short step and retry counts
// Notes:   one step is 4 cycles, retry 50 cycles
`timescale 1ns/10ps
module output_overvoltage_fault_response_tb_top import ovr_pkg::*; ;
   // ==================================
   // signals
   logic       clk = 0, reset = 1, wr_en = 0, reset_cmd = 0;
   logic [7:0] wr_cmd = 8'h41, wr_data = 8'h00, cfg_rd;
   logic       ov_pin = 0, run_pin = 1, alert_mask = 0, ack_req = 0;
   logic       clear_faults, cml_fault, alert_n, out_enable;
   logic       top_off, bot_on;
   ovr_flags_t flags, seen;
   int         bad_count = 0, cmp_count = 0;
   logic [7:0] ok_codes [7] = '{8'h00, 8'h80, 8'h40, 8'h47,
                                 8'h78, 8'h7f, 8'hb8};
   logic [7:0] bad_codes [4] = '{8'hc0, 8'h48, 8'h01, 8'hff};
   always #5 clk = ~clk;
   ovr_resp #(.RETRY_CYC(50), .STEP_CYC(4)) dut_u (
      .clk(clk), .reset(reset), .wr_en(wr_en), .wr_cmd(wr_cmd),
      .wr_data(wr_data), .clear_faults(clear_faults),
      .reset_cmd(reset_cmd), .cfg_rd(cfg_rd), .cml_fault(cml_fault),
      .ov_pin(ov_pin), .run_pin(run_pin), .op_on(1'b1),
      .other_fault_off(1'b0), .alert_mask(alert_mask), .flags(flags),
      .alert_n(alert_n), .out_enable(out_enable), .top_off(top_off),
      .bot_on(bot_on));
   ovr_host host_u (.clk(clk), .alert_n(alert_n), .flags(flags),
      .ack_req(ack_req), .seen(seen), .clear_faults(clear_faults));
   // ==================================
   // helpers
   task final_report;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   // one-cycle write strobe, looked at after the taking edge
   task wr(input logic [7:0] d);
      @(posedge clk) begin wr_en <= 1; wr_data <= d; end
      @(posedge clk) wr_en <= 0;
      #1;
   endtask
   // bounded wait, a miss ends the run
   task wait_oe(input logic v, input int n);
      int i;
      i = 0;
      #1;
      while (out_enable !== v && i < n) begin
         @(posedge clk) #1;
         i++;
      end
      chk(out_enable === v, "output enable");
      if (out_enable !== v) final_report();
   endtask
   task ov_set(input logic v, input int n);
      @(posedge clk) ov_pin <= v;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task clr;
      @(posedge clk) ack_req <= 1;
      repeat (4) @(posedge clk);
      ack_req <= 0;
      #1;
   endtask
   // ==================================
   // scenarios
   task s_codes;
      foreach (ok_codes[i]) begin
         wr(ok_codes[i]);
         chk(cfg_rd === ok_codes[i] && cml_fault === 1'b0, "legal");
      end
      foreach (bad_codes[i]) begin
         wr(bad_codes[i]);
         chk(cml_fault === 1'b1 && cfg_rd === 8'hb8, "refused");
         @(posedge clk) #1;
         chk(cml_fault === 1'b0, "fault pulse");
      end
      // a write to another command leaves this byte alone
      @(posedge clk) wr_cmd <= 8'h45;
      wr(8'h00);
      chk(cfg_rd === 8'hb8 && cml_fault === 1'b0, "other cmd");
      @(posedge clk) wr_cmd <= 8'h41;
   endtask
   task s_off;
      wr(8'h80);
      ov_set(1, 5);
      chk(flags === 3'b111 && alert_n === 1'b0, "flags");
      wait_oe(0, 4);
      ov_set(0, 70);
      chk(out_enable === 1'b0 && flags === 3'b111, "stays");
      clr();
      chk(seen === 3'b111 && flags === 3'b000, "cleared");
      @(posedge clk) reset_cmd <= 1;
      @(posedge clk) reset_cmd <= 0;
      wait_oe(1, 10);
   endtask
   task s_pull;
      wr(8'h00);
      ov_set(1, 6);
      chk(top_off === 1 && bot_on === 1 && out_enable === 1, "pull");
      ov_set(0, 4);
      chk(top_off === 1'b0 && bot_on === 1'b0, "pull end");
      clr();
   endtask
   task s_degl;
      wr(8'h43);
      ov_set(1, 8);
      ov_set(0, 4);
      ov_set(1, 8);
      ov_set(0, 20);
      chk(out_enable === 1'b1, "glitch");
      ov_set(1, 0);
      wait_oe(0, 30);
      ov_set(0, 70);
      chk(out_enable === 1'b0, "no retry");
      @(posedge clk) run_pin <= 0;
      repeat (4) @(posedge clk);
      run_pin <= 1;
      wait_oe(1, 20);
      chk(flags === 3'b000, "off on");
   endtask
   task s_retry;
      wr(8'hb8);
      ov_set(1, 0);
      wait_oe(0, 10);
      ov_set(0, 30);
      chk(out_enable === 1'b0, "retry early");
      wait_oe(1, 80);
      clr();
   endtask
   task s_mask;
      @(posedge clk) alert_mask <= 1;
      wr(8'h00);
      ov_set(1, 6);
      chk(alert_n === 1'b1 && flags === 3'b111, "masked");
      ov_set(0, 2);
   endtask
   // ==================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      reset <= 0;
      #1;
      chk(cfg_rd === 8'hb8 && flags === 3'b000, "reset cfg");
      chk(alert_n === 1'b1 && out_enable === 1'b1, "reset out");
      s_codes();
      s_off();
      s_pull();
      s_degl();
      s_retry();
      s_mask();
      final_report();
   end
endmodule
